// File: logic/parity_csr_pkg.sv
`default_nettype none
package parity_csr_pkg;
    localparam int ADDR_W = 22;
    localparam int DATA_W = 16;

    // Register base word addresses (octal 772100 and 17772100)
    localparam logic [17:0] CSR_BASE_PRI = 18'h3F440;
    localparam logic [21:0] CSR_BASE_SPC = 22'h3FF440;

    // Field positions
    localparam int BIT_ENABLE = 0;
    localparam int BIT_WWP    = 2;
    localparam int ERR_LSB    = 5;
    localparam int ERR_LO_W   = 7;
    localparam int ERR_HI_W   = 4;
    localparam int BIT_HISEL  = 14;
    localparam int BIT_FLAG   = 15;
    localparam int LO_ADDR_LSB = 11;
    localparam int HI_ADDR_LSB = 18;

    // Values after reset
    localparam logic [DATA_W-1:0]   CSR_RESET    = 16'h0000;
    localparam logic [ERR_LO_W-1:0] ERR_LO_RESET = 7'h00;
    localparam logic [ERR_HI_W-1:0] ERR_HI_RESET = 4'h0;

    // Odd parity: stored bit makes the count of ones odd
    localparam logic PAR_ODD = 1'b1;

    typedef enum logic [1:0] {
        WORD_READ_CYCLE  = 2'h0,
        READ_PAUSE_CYCLE = 2'h1,
        WORD_WRITE_CYCLE = 2'h2,
        BYTE_WRITE_CYCLE = 2'h3
    } cycle_e;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'h0,
        ST_ACCESS = 2'h1,
        ST_ANSWER = 2'h3
    } state_e;

    function automatic logic byte_par(input logic [7:0] b);
        return (^b) ^ PAR_ODD;
    endfunction
endpackage
`default_nettype wire

// File: logic/parity_mem_if.sv
`timescale 1ns/100ps
`default_nettype none
interface parity_mem_if #(parameter int AW = 10) ();
    logic          wr_en;
    logic          rd_en;
    logic [1:0]    byte_en;
    logic [AW-1:0] addr;
    logic [15:0]   wdata;
    logic          wrong_par;
    logic [15:0]   rdata;
    logic          par_err;

    modport ctrl  (output wr_en, rd_en, byte_en, addr, wdata, wrong_par,
                   input  rdata, par_err);
    modport store (input  wr_en, rd_en, byte_en, addr, wdata, wrong_par,
                   output rdata, par_err);
endinterface
`default_nettype wire

// File: logic/parity_store.sv
`timescale 1ns/100ps
`default_nettype none
module parity_store #(
    parameter int AW = 10
) (
    // Clock and reset
    input  wire logic   mclk,
    input  wire logic   arst_n,
    // Array port
    parity_mem_if.store mem
);
    import parity_csr_pkg::*;

    localparam int DEPTH = 1 << AW;

    // Array is not reset; a word must be written before its parity means anything
    logic [15:0] data_mem [0:DEPTH-1];
    logic [1:0]  par_mem  [0:DEPTH-1];
    logic [15:0] rdata_r;
    logic [1:0]  rpar_r;
    logic        rvld_r;
    logic        rvld_nxt;
    logic [1:0]  wpar;

    always_comb begin
        rvld_nxt = mem.rd_en;
        wpar     = {byte_par(mem.wdata[15:8]), byte_par(mem.wdata[7:0])}
                   ^ {2{mem.wrong_par}};
    end

    always_ff @(posedge mclk) begin
        if (mem.wr_en && mem.byte_en[1]) begin
            data_mem[mem.addr][15:8] <= mem.wdata[15:8];
            par_mem[mem.addr][1]     <= wpar[1];
        end
        if (mem.wr_en && mem.byte_en[0]) begin
            data_mem[mem.addr][7:0] <= mem.wdata[7:0];
            par_mem[mem.addr][0]    <= wpar[0];
        end
        if (mem.rd_en) begin
            rdata_r <= data_mem[mem.addr];
            rpar_r  <= par_mem[mem.addr];
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rvld_r <= 1'b0;
        end else begin
            rvld_r <= rvld_nxt;
        end
    end

    assign mem.rdata   = rdata_r;
    assign mem.par_err = rvld_r &&
        (rpar_r != {byte_par(rdata_r[15:8]), byte_par(rdata_r[7:0])});

    a_wrong_par_store: assert property (@(posedge mclk) disable iff (!arst_n)
        (mem.wr_en && mem.byte_en == 2'h3 && mem.wrong_par) |=>
        par_mem[$past(mem.addr)] ==
        ~{byte_par($past(mem.wdata[15:8])), byte_par($past(mem.wdata[7:0]))})
        else $error("inverted parity not stored");
endmodule // parity_store
`default_nettype wire

// File: logic/parity_error_status_register.sv
`timescale 1ns/100ps
`default_nettype none
module parity_error_status_register #(
    parameter int MEM_AW = 10
) (
    // Clock and reset
    input  wire logic                              mclk,
    input  wire logic                              arst_n,
    // Bus control
    input  wire logic                              bus_init,
    input  wire logic                              special_bus_mode,
    input  wire logic [3:0]                        address_select_switch,
    // Bus request
    input  wire logic                              bus_req,
    input  wire parity_csr_pkg::cycle_e            bus_cycle,
    input  wire logic [parity_csr_pkg::ADDR_W-1:0] bus_addr,
    input  wire logic [parity_csr_pkg::DATA_W-1:0] bus_wdata,
    // Bus answer
    output logic                                   bus_ack,
    output logic [parity_csr_pkg::DATA_W-1:0]      bus_rdata,
    output logic                                   bus_parity_error_line,
    // Indicator
    output logic                                   error_lamp
);
    import parity_csr_pkg::*;

    parity_mem_if #(.AW(MEM_AW)) mem ();

    parity_store #(
        .AW(MEM_AW)
    ) u_store (
        .mclk   (mclk),
        .arst_n (arst_n),
        .mem    (mem.store)
    );

    // Register state
    logic                enable_r,  enable_nxt;
    logic                wwp_r,     wwp_nxt;
    logic                hisel_r,   hisel_nxt;
    logic                flag_r,    flag_nxt;
    logic [ERR_LO_W-1:0] err_lo_r,  err_lo_nxt;
    logic [ERR_HI_W-1:0] err_hi_r,  err_hi_nxt;

    // Access sequencing
    state_e              state_r,   state_nxt;
    logic                pend_csr_r,  pend_csr_nxt;
    logic                pend_read_r, pend_read_nxt;
    logic [ERR_LO_W-1:0] pend_lo_r,   pend_lo_nxt;
    logic [ERR_HI_W-1:0] pend_hi_r,   pend_hi_nxt;

    // Answer registers
    logic                ack_r,     ack_nxt;
    logic [DATA_W-1:0]   rdata_r,   rdata_nxt;
    logic                pbl_r,     pbl_nxt;

    // Decode helpers
    logic [ADDR_W-1:0]   eff_addr;
    logic                req_csr;
    logic                req_read;
    logic                err_set;
    logic [DATA_W-1:0]   csr_rd;

    function automatic logic csr_hit(input logic [ADDR_W-1:0] a,
                                     input logic              spc,
                                     input logic [3:0]        sw);
        logic hit;
        hit = 1'b0;
        if (a[4:1] != sw) begin
            hit = 1'b0;
        end else if (spc) begin
            hit = (a[21:5] == CSR_BASE_SPC[21:5]);
        end else begin
            hit = (a[17:5] == CSR_BASE_PRI[17:5]);
        end
        return hit;
    endfunction

    function automatic logic is_read_cycle(input cycle_e c);
        return (c == WORD_READ_CYCLE) || (c == READ_PAUSE_CYCLE);
    endfunction

    // Upper address receivers are off on the primary bus
    always_comb begin
        eff_addr = special_bus_mode ? bus_addr : {4'h0, bus_addr[17:0]};
        req_csr  = csr_hit(eff_addr, special_bus_mode, address_select_switch);
        req_read = is_read_cycle(bus_cycle);
    end

    // Read view of the register
    always_comb begin
        csr_rd              = CSR_RESET;
        csr_rd[BIT_FLAG]    = flag_r;
        csr_rd[BIT_HISEL]   = hisel_r;
        if (hisel_r) begin
            csr_rd[ERR_LSB +: ERR_HI_W] = err_hi_r;
        end else begin
            csr_rd[ERR_LSB +: ERR_LO_W] = err_lo_r;
        end
        csr_rd[BIT_WWP]     = wwp_r;
        csr_rd[BIT_ENABLE]  = enable_r;
    end

    always_comb begin
        state_nxt     = state_r;
        enable_nxt    = enable_r;
        wwp_nxt       = wwp_r;
        hisel_nxt     = hisel_r;
        flag_nxt      = flag_r;
        err_lo_nxt    = err_lo_r;
        err_hi_nxt    = err_hi_r;
        pend_csr_nxt  = pend_csr_r;
        pend_read_nxt = pend_read_r;
        pend_lo_nxt   = pend_lo_r;
        pend_hi_nxt   = pend_hi_r;
        ack_nxt       = 1'b0;
        rdata_nxt     = rdata_r;
        pbl_nxt       = 1'b0;
        err_set       = 1'b0;

        mem.wr_en     = 1'b0;
        mem.rd_en     = 1'b0;
        mem.addr      = eff_addr[MEM_AW:1];
        mem.wdata     = bus_wdata;
        mem.wrong_par = wwp_r;
        if (bus_cycle == BYTE_WRITE_CYCLE) begin
            mem.byte_en = eff_addr[0] ? 2'h2 : 2'h1;
        end else begin
            mem.byte_en = 2'h3;
        end

        case (state_r)
            ST_IDLE: begin
                // The register path never waits on refresh or the array
                if (bus_req) begin
                    state_nxt     = ST_ACCESS;
                    pend_csr_nxt  = req_csr;
                    pend_read_nxt = req_read;
                    pend_lo_nxt   = eff_addr[LO_ADDR_LSB +: ERR_LO_W];
                    pend_hi_nxt   = eff_addr[HI_ADDR_LSB +: ERR_HI_W];
                    if (req_csr && !req_read) begin
                        // Byte writes load the whole word, bit 0 not decoded
                        enable_nxt = bus_wdata[BIT_ENABLE];
                        wwp_nxt    = bus_wdata[BIT_WWP];
                        flag_nxt   = bus_wdata[BIT_FLAG];
                        hisel_nxt  = special_bus_mode && bus_wdata[BIT_HISEL];
                        // Field written is the one being viewed
                        if (hisel_r) begin
                            err_hi_nxt = bus_wdata[ERR_LSB +: ERR_HI_W];
                        end else begin
                            err_lo_nxt = bus_wdata[ERR_LSB +: ERR_LO_W];
                        end
                    end else if (!req_csr && req_read) begin
                        mem.rd_en = 1'b1;
                    end else if (!req_csr) begin
                        mem.wr_en = 1'b1;
                    end
                end
            end
            ST_ACCESS: begin
                state_nxt = ST_ANSWER;
                ack_nxt   = 1'b1;
                rdata_nxt = 16'h0000;
                if (pend_read_r && pend_csr_r) begin
                    rdata_nxt = csr_rd;
                end else if (pend_read_r) begin
                    rdata_nxt = mem.rdata;
                    err_set   = mem.par_err;
                    pbl_nxt   = mem.par_err && enable_r;
                end
            end
            ST_ANSWER: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase

        if (bus_init) begin
            enable_nxt = 1'b0;
            wwp_nxt    = 1'b0;
            hisel_nxt  = 1'b0;
            flag_nxt   = 1'b0;
        end
        if (!special_bus_mode) begin
            hisel_nxt = 1'b0;
        end
        // Detected error wins over an initialise in the same cycle
        if (err_set) begin
            flag_nxt   = 1'b1;
            err_lo_nxt = pend_lo_r;
            err_hi_nxt = pend_hi_r;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_r     <= ST_IDLE;
            enable_r    <= 1'b0;
            wwp_r       <= 1'b0;
            hisel_r     <= 1'b0;
            flag_r      <= 1'b0;
            err_lo_r    <= ERR_LO_RESET;
            err_hi_r    <= ERR_HI_RESET;
            pend_csr_r  <= 1'b0;
            pend_read_r <= 1'b0;
            pend_lo_r   <= ERR_LO_RESET;
            pend_hi_r   <= ERR_HI_RESET;
            ack_r       <= 1'b0;
            rdata_r     <= CSR_RESET;
            pbl_r       <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            enable_r    <= enable_nxt;
            wwp_r       <= wwp_nxt;
            hisel_r     <= hisel_nxt;
            flag_r      <= flag_nxt;
            err_lo_r    <= err_lo_nxt;
            err_hi_r    <= err_hi_nxt;
            pend_csr_r  <= pend_csr_nxt;
            pend_read_r <= pend_read_nxt;
            pend_lo_r   <= pend_lo_nxt;
            pend_hi_r   <= pend_hi_nxt;
            ack_r       <= ack_nxt;
            rdata_r     <= rdata_nxt;
            pbl_r       <= pbl_nxt;
        end
    end

    // Lamp is the flag itself; nothing here reaches a trap
    assign bus_ack               = ack_r;
    assign bus_rdata             = rdata_r;
    assign bus_parity_error_line = pbl_r;
    assign error_lamp            = flag_r;

    a_answer_timing: assert property (@(posedge mclk) disable iff (!arst_n)
        (state_r == ST_IDLE && bus_req) |-> ##2 (bus_ack && state_r == ST_ANSWER))
        else $error("access not answered two edges after it was taken");

    a_unused_bits_zero: assert property (@(posedge mclk) disable iff (!arst_n)
        (ack_r && $past(pend_csr_r) && $past(pend_read_r)) |->
        (bus_rdata[13:12] == 2'h0 && bus_rdata[4:3] == 2'h0 && !bus_rdata[1]))
        else $error("unused register bits read nonzero");

    a_parity_line_cause: assert property (@(posedge mclk) disable iff (!arst_n)
        bus_parity_error_line |-> ($past(enable_r) && $past(mem.par_err)
                                   && $past(state_r) == ST_ACCESS))
        else $error("parity error line without enabled read error");

    a_parity_line_set: assert property (@(posedge mclk) disable iff (!arst_n)
        (state_r == ST_ACCESS && pend_read_r && !pend_csr_r && mem.par_err && enable_r)
        |=> (bus_parity_error_line && bus_ack) ##1 !bus_parity_error_line)
        else $error("enabled read parity error not signalled for one cycle");

    a_init_clears: assert property (@(posedge mclk) disable iff (!arst_n)
        bus_init |=> (!enable_r && !wwp_r && !hisel_r && (!flag_r || $past(err_set))))
        else $error("initialise left a control bit set");

    a_init_keeps_addr: assert property (@(posedge mclk) disable iff (!arst_n)
        (bus_init && state_r == ST_IDLE && !bus_req)
        |=> ($stable(err_lo_r) && $stable(err_hi_r)))
        else $error("initialise disturbed error address");

    a_error_capture: assert property (@(posedge mclk) disable iff (!arst_n)
        err_set |=> (flag_r && error_lamp && err_lo_r == $past(pend_lo_r)
                     && err_hi_r == $past(pend_hi_r)))
        else $error("parity error not captured");

    a_primary_hisel_zero: assert property (@(posedge mclk) disable iff (!arst_n)
        !special_bus_mode |=> (!hisel_r && err_hi_r == $past(err_hi_r) || $past(err_set)))
        else $error("high select set on primary bus");

    a_high_view: assert property (@(posedge mclk) disable iff (!arst_n)
        hisel_r |-> (csr_rd[11:9] == 3'h0 && csr_rd[8:5] == err_hi_r))
        else $error("high address view wrong");

    a_low_view: assert property (@(posedge mclk) disable iff (!arst_n)
        !hisel_r |-> (csr_rd[11:5] == err_lo_r && csr_rd[15] == flag_r))
        else $error("low address view wrong");

    a_write_loads_ctrl: assert property (@(posedge mclk) disable iff (!arst_n)
        (state_r == ST_IDLE && bus_req && req_csr && !req_read && !bus_init)
        |=> (enable_r == $past(bus_wdata[BIT_ENABLE])
             && wwp_r == $past(bus_wdata[BIT_WWP])))
        else $error("register write did not load control bits");

    a_write_loads_flag: assert property (@(posedge mclk) disable iff (!arst_n)
        (state_r == ST_IDLE && bus_req && req_csr && !req_read && !bus_init)
        |=> (flag_r == $past(bus_wdata[BIT_FLAG])))
        else $error("register write did not load the flag");

    a_ack_one_cycle: assert property (@(posedge mclk) disable iff (!arst_n)
        bus_ack |=> !bus_ack)
        else $error("answer held longer than one cycle");

    a_csr_no_parity: assert property (@(posedge mclk) disable iff (!arst_n)
        (state_r == ST_ACCESS && pend_csr_r) |=> !bus_parity_error_line)
        else $error("parity error line raised on a register access");

    a_csr_off_array: assert property (@(posedge mclk) disable iff (!arst_n)
        (state_r == ST_IDLE && bus_req && req_csr) |-> (!mem.wr_en && !mem.rd_en))
        else $error("register access reached the array");

    a_primary_upper_zero: assert property (@(posedge mclk) disable iff (!arst_n)
        (err_set && !special_bus_mode) |=> (err_hi_r == 4'h0))
        else $error("upper error address loaded on primary bus");
endmodule // parity_error_status_register
`default_nettype wire

// File: tb/bus_master_model.sv
`timescale 1ns/100ps
`default_nettype none
module bus_master_model (
    // Clock and reset
    input  wire logic                              mclk,
    input  wire logic                              arst_n,
    // Command from the bench
    input  wire logic                              go,
    input  wire parity_csr_pkg::cycle_e            go_cycle,
    input  wire logic [parity_csr_pkg::ADDR_W-1:0] go_addr,
    input  wire logic [parity_csr_pkg::DATA_W-1:0] go_wdata,
    output logic                                   done,
    // Bus side
    output logic                                   bus_req,
    output var parity_csr_pkg::cycle_e             bus_cycle,
    output logic [parity_csr_pkg::ADDR_W-1:0]      bus_addr,
    output logic [parity_csr_pkg::DATA_W-1:0]      bus_wdata,
    input  wire logic                              bus_ack
);
    import parity_csr_pkg::*;

    // Request held until the answer is sampled; released address and data lines show inverted
    // values so a design that latches late sees garbage, not the old value
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            bus_req   <= 1'h0;
            bus_cycle <= WORD_READ_CYCLE;
            bus_addr  <= '0;
            bus_wdata <= '0;
            done      <= 1'h0;
        end else begin
            done <= 1'h0;
            if (bus_req && bus_ack) begin
                bus_req   <= 1'h0;
                bus_addr  <= ~bus_addr;
                bus_wdata <= ~bus_wdata;
                done      <= 1'h1;
            end else if (!bus_req && go) begin
                bus_req   <= 1'h1;
                bus_cycle <= go_cycle;
                bus_addr  <= go_addr;
                bus_wdata <= go_wdata;
            end
        end
    end
endmodule // bus_master_model
`default_nettype wire

// File: tb/parity_error_status_register_bench.sv
`timescale 1ns/100ps
`default_nettype none
module parity_error_status_register_bench;
    import parity_csr_pkg::*;

    logic                mclk;
    logic                arst_n;
    logic                bus_init;
    logic                special_bus_mode;
    logic [3:0]          address_select_switch;
    logic                go;
    logic                done;
    cycle_e              go_cycle;
    cycle_e              bus_cycle;
    logic [ADDR_W-1:0]   go_addr;
    logic [ADDR_W-1:0]   bus_addr;
    logic [DATA_W-1:0]   go_wdata;
    logic [DATA_W-1:0]   bus_wdata;
    logic [DATA_W-1:0]   bus_rdata;
    logic                bus_req;
    logic                bus_ack;
    logic                bus_parity_error_line;
    logic                error_lamp;
    logic [16:0]         notes[$];
    logic [16:0]         note;
    logic [31:0]         seed;
    logic [15:0]         d1;
    logic [15:0]         d2;
    logic [3:0]          hi;
    int                  err_count;
    int                  comparisons;

    parity_error_status_register #(.MEM_AW(4)) u_parity_error_status_register (
        .mclk(mclk), .arst_n(arst_n), .bus_init(bus_init),
        .special_bus_mode(special_bus_mode), .address_select_switch(address_select_switch),
        .bus_req(bus_req), .bus_cycle(bus_cycle), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_ack(bus_ack), .bus_rdata(bus_rdata),
        .bus_parity_error_line(bus_parity_error_line), .error_lamp(error_lamp));

    bus_master_model u_bus_master_model (
        .mclk(mclk), .arst_n(arst_n), .go(go), .go_cycle(go_cycle), .go_addr(go_addr),
        .go_wdata(go_wdata), .done(done), .bus_req(bus_req), .bus_cycle(bus_cycle),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_ack(bus_ack));

    initial begin
        mclk = 1'h0;
        forever #20 mclk = ~mclk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Bit 0 always set: the decoder must ignore it
    function automatic logic [21:0] csr_at(input logic [3:0] h);
        return (special_bus_mode ? CSR_BASE_SPC : {h, CSR_BASE_PRI})
               | {17'h00000, address_select_switch, 1'h1};
    endfunction

    function automatic logic [21:0] mem_at(input logic [3:0] h, input logic [6:0] l,
                                           input logic [3:0] idx);
        return {h, l, 6'h00, idx, 1'h0};
    endfunction

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s seen %h wanted %h", $time, what, seen, exp);
        end
    endtask

    task automatic access(input cycle_e c, input logic [21:0] a, input logic [15:0] d,
                          input logic [16:0] exp);
        int n;
        notes.push_back(exp);
        go       <= 1'h1;
        go_cycle <= c;
        go_addr  <= a;
        go_wdata <= d;
        @(posedge mclk);
        go <= 1'h0;
        n = 0;
        while (done !== 1'h1 && n < 20) begin
            @(posedge mclk);
            n++;
        end
        if (n == 20) begin
            err_count++;
            $display("unexpected at %0t: no answer from the block", $time);
            tally_and_finish();
        end
    endtask

    task automatic rd(input cycle_e c, input logic [21:0] a, input logic [15:0] e,
                      input logic p);
        access(c, a, 16'h0000, {p, e});
    endtask

    task automatic wr(input cycle_e c, input logic [21:0] a, input logic [15:0] d);
        access(c, a, d, 17'h00000);
    endtask

    task automatic pulse_init();
        bus_init <= 1'h1;
        @(posedge mclk);
        bus_init <= 1'h0;
        @(posedge mclk);
    endtask

    // Every answer is matched against the oldest note left by the driver
    always @(posedge mclk) begin
        if (bus_ack === 1'h1) begin
            if (notes.size() == 0) begin
                check(16'h0001, 16'h0000, "answer without request");
            end else begin
                note = notes.pop_front();
                check(bus_rdata, note[15:0], "read data");
                check({15'h0000, bus_parity_error_line}, {15'h0000, note[16]}, "parity");
            end
        end
    end

    initial begin
        arst_n = 1'h0;
        bus_init = 1'h0;
        special_bus_mode = 1'h0;
        address_select_switch = 4'h0;
        go = 1'h0;
        go_cycle = WORD_READ_CYCLE;
        go_addr = '0;
        go_wdata = '0;
        seed = 32'hFB7B;
        err_count = 0;
        comparisons = 0;
        repeat (8) @(posedge mclk);
        arst_n <= 1'h1;
        seed = lfsr(seed);
        address_select_switch <= seed[3:0];
        hi = seed[7:4];
        @(posedge mclk);
        rd(WORD_READ_CYCLE, csr_at(hi), 16'h0000, 1'h0);
        wr(BYTE_WRITE_CYCLE, csr_at(~hi), 16'hFFFF);
        rd(WORD_READ_CYCLE, csr_at(hi), 16'h8FE5, 1'h0);
        check({15'h0000, error_lamp}, 16'h0001, "lamp on");
        $display("test register fields done");
        pulse_init();
        rd(WORD_READ_CYCLE, csr_at(hi), 16'h0FE0, 1'h0);
        check({15'h0000, error_lamp}, 16'h0000, "lamp off");
        $display("test bus initialise done");
        seed = lfsr(seed);
        d1 = seed[15:0];
        seed = lfsr(seed);
        d2 = seed[15:0];
        wr(WORD_WRITE_CYCLE, csr_at(hi), 16'h0001);
        wr(WORD_WRITE_CYCLE, mem_at(hi, 7'h15, 4'h1), d1);
        rd(WORD_READ_CYCLE, mem_at(hi, 7'h15, 4'h1), d1, 1'h0);
        wr(WORD_WRITE_CYCLE, csr_at(hi), 16'h0005);
        wr(BYTE_WRITE_CYCLE, mem_at(hi, 7'h15, 4'h1) | 22'h000001, d2);
        rd(WORD_READ_CYCLE, mem_at(hi, 7'h15, 4'h1), {d2[15:8], d1[7:0]}, 1'h1);
        rd(READ_PAUSE_CYCLE, mem_at(hi, 7'h15, 4'h1), {d2[15:8], d1[7:0]}, 1'h1);
        rd(WORD_READ_CYCLE, csr_at(hi), 16'h8005 | (16'h0015 << 5), 1'h0);
        check({15'h0000, error_lamp}, 16'h0001, "lamp after error");
        $display("test wrong parity done");
        wr(WORD_WRITE_CYCLE, csr_at(hi), 16'h0004);
        wr(WORD_WRITE_CYCLE, mem_at(hi, 7'h2A, 4'h2), d2);
        wr(WORD_WRITE_CYCLE, csr_at(hi), 16'h0000);
        rd(WORD_READ_CYCLE, mem_at(hi, 7'h2A, 4'h2), d2, 1'h0);
        rd(WORD_READ_CYCLE, csr_at(hi), 16'h8000 | (16'h002A << 5), 1'h0);
        $display("test disabled indication done");
        special_bus_mode <= 1'h1;
        @(posedge mclk);
        wr(WORD_WRITE_CYCLE, csr_at(hi), 16'h0005);
        wr(WORD_WRITE_CYCLE, mem_at(hi, 7'h33, 4'h3), d1);
        wr(WORD_WRITE_CYCLE, csr_at(hi), 16'h0001);
        rd(WORD_READ_CYCLE, mem_at(hi, 7'h33, 4'h3), d1, 1'h1);
        rd(WORD_READ_CYCLE, csr_at(hi), 16'h8001 | (16'h0033 << 5), 1'h0);
        wr(WORD_WRITE_CYCLE, csr_at(hi), 16'hC001 | (16'h0033 << 5));
        rd(WORD_READ_CYCLE, csr_at(hi), 16'hC001 | ({12'h000, hi} << 5), 1'h0);
        pulse_init();
        rd(WORD_READ_CYCLE, csr_at(hi), 16'h0033 << 5, 1'h0);
        $display("test special bus retrieval done");
        repeat (3) @(posedge mclk);
        check(16'(notes.size()), 16'h0000, "answers missing");
        tally_and_finish();
    end
endmodule // parity_error_status_register_bench
`default_nettype wire
